// ---- uart_window_pkg.sv ----
package uart_window_pkg;
    localparam logic [2:0] OFS_HOLD = 3'h0;
    localparam logic [2:0] OFS_IEN = 3'h1;
    localparam logic [2:0] OFS_FIFO = 3'h2;
    localparam logic [2:0] OFS_LFC = 3'h3;
    localparam logic [2:0] OFS_MLC = 3'h4;
    localparam logic [2:0] OFS_LST = 3'h5;
    localparam logic [2:0] OFS_MST = 3'h6;
    localparam logic [2:0] OFS_SCR = 3'h7;
    localparam logic [2:0] OFS_IDXWIN = 3'h5;
    localparam logic [7:0] ENH_KEY = 8'hbf;
    localparam int DLAB_BIT = 7;
    localparam int SET950_BIT = 7;
    localparam int IDXRD_BIT = 6;
    localparam logic [7:0] IDX_SETUP = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_LFC = 8'h03;
    localparam int IDX_DEPTH = 16;
    typedef enum logic [4:0] {
        SEL_BASE = 5'b00001,
        SEL_DIV = 5'b00010,
        SEL_650 = 5'b00100,
        SEL_950 = 5'b01000,
        SEL_IDX = 5'b10000
    } sel_t;
endpackage

// ---- uart_icr_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
module uart_indexed_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Access
    input wire logic [7:0] idx,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic [7:0] setup_byte
);
    import uart_window_pkg::*;
    logic [7:0] mem_q [IDX_DEPTH];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < IDX_DEPTH; i++) mem_q[i] <= RST_BYTE;
        end else if (wr && idx < 8'(IDX_DEPTH)) begin
            mem_q[idx[3:0]] <= wdata;
        end
    end
    assign rdata = (idx < 8'(IDX_DEPTH)) ? mem_q[idx[3:0]] : RST_BYTE;
    assign setup_byte = mem_q[IDX_SETUP[3:0]];
endmodule // uart_indexed_bank
`default_nettype wire

// ---- uart_register_window_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
module uart_register_window_decode (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Host byte bus
    input wire logic [2:0] addr,
    input wire logic cs,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // Transmit and receive paths
    output logic tx_push,
    output logic [7:0] tx_data,
    output logic tx_bit9,
    output logic rx_pop,
    input wire logic [7:0] rx_data,
    input wire logic nine_bit_mode,
    // Status inputs and 650/950 set
    input wire logic [7:0] int_source,
    input wire logic [7:0] line_state,
    input wire logic [7:0] modem_line_state,
    input wire logic [7:0] ext_rdata,
    output logic ext_wr,
    output logic ext_rd,
    output uart_window_pkg::sel_t ext_set,
    // Control state
    output logic [15:0] baud_divisor,
    output logic [7:0] line_format_control,
    output logic [7:0] int_enable_mask,
    output logic [7:0] fifo_setup,
    output logic [7:0] modem_line_control,
    output logic [7:0] additional_setup_reg
);
    import uart_window_pkg::*;

    // ==========================================
    // Decode
    logic [7:0] lfc_q, ien_q, fifo_q, mlc_q, scr_q, div_lo_q, div_hi_q;
    logic key_q;
    logic [7:0] idx_rdata;
    logic idx_wr;
    logic wr, rd;
    sel_t sel;

    function automatic sel_t decode(input logic [2:0] a, input logic dlab, input logic key,
                                    input logic [7:0] setup, input logic is_rd);
        sel_t s;
        s = SEL_BASE;
        if (key && !(a == OFS_HOLD || a == OFS_LFC)) s = SEL_650;
        else if (dlab && (a == OFS_HOLD || a == OFS_IEN)) s = SEL_DIV;
        else if (!key && a == OFS_IDXWIN && (setup[IDXRD_BIT] || !is_rd)) s = SEL_IDX;
        // Offset 0 stays with the holding registers so transmit keeps working
        else if (!key && setup[SET950_BIT] && a != OFS_HOLD && a != OFS_LFC && a != OFS_SCR && !dlab) begin
            s = SEL_950;
        end
        return s;
    endfunction

    assign wr = cs && wr_stb;
    assign rd = cs && rd_stb;
    assign sel = decode(addr, lfc_q[DLAB_BIT], key_q, additional_setup_reg, rd);

    // ==========================================
    // Line format and 650 key
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lfc_q <= RST_LFC;
            key_q <= 1'b0;
        end else if (wr && addr == OFS_LFC) begin
            if (wdata == ENH_KEY) begin
                lfc_q <= {1'b1, lfc_q[6:0]};
                key_q <= 1'b1;
            end else begin
                lfc_q <= wdata;
                key_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // Base and divisor registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_lo_q <= RST_BYTE;
            div_hi_q <= RST_BYTE;
            ien_q <= RST_BYTE;
            fifo_q <= RST_BYTE;
            mlc_q <= RST_BYTE;
            scr_q <= RST_BYTE;
        end else if (wr) begin
            if (sel == SEL_DIV && addr == OFS_HOLD) div_lo_q <= wdata;
            if (sel == SEL_DIV && addr == OFS_IEN) div_hi_q <= wdata;
            if (sel == SEL_BASE && addr == OFS_IEN) ien_q <= wdata;
            if (sel == SEL_BASE && addr == OFS_FIFO) fifo_q <= wdata;
            if (sel == SEL_BASE && addr == OFS_MLC) mlc_q <= wdata;
            if (sel == SEL_BASE && addr == OFS_SCR) scr_q <= wdata;
        end
    end

    // ==========================================
    // Transmit path
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_push <= 1'b0;
            tx_data <= RST_BYTE;
        end else begin
            tx_push <= wr && sel == SEL_BASE && addr == OFS_HOLD;
            if (wr && sel == SEL_BASE && addr == OFS_HOLD) tx_data <= wdata;
        end
    end
    assign tx_bit9 = nine_bit_mode & scr_q[0];
    assign rx_pop = rd && sel == SEL_BASE && addr == OFS_HOLD;

    // ==========================================
    // Indexed control set
    assign idx_wr = wr && sel == SEL_IDX;
    uart_indexed_bank u_idx (
        .clk(clk),
        .rstn(rstn),
        .idx(scr_q),
        .wr(idx_wr),
        .wdata(wdata),
        .rdata(idx_rdata),
        .setup_byte(additional_setup_reg)
    );

    assign ext_wr = wr && (sel == SEL_650 || sel == SEL_950);
    assign ext_rd = rd && (sel == SEL_650 || sel == SEL_950);
    assign ext_set = sel;

    // ==========================================
    // Read data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= RST_BYTE;
        end else if (rd) begin
            unique case (sel)
                SEL_DIV: rdata <= (addr == OFS_HOLD) ? div_lo_q : div_hi_q;
                SEL_650, SEL_950: rdata <= ext_rdata;
                SEL_IDX: rdata <= idx_rdata;
                SEL_BASE: begin
                    unique case (addr)
                        OFS_HOLD: rdata <= rx_data;
                        OFS_IEN: rdata <= ien_q;
                        OFS_FIFO: rdata <= int_source;
                        OFS_LFC: rdata <= lfc_q;
                        OFS_MLC: rdata <= mlc_q;
                        OFS_LST: rdata <= line_state;
                        OFS_MST: rdata <= modem_line_state;
                        OFS_SCR: rdata <= scr_q;
                    endcase
                end
                default: rdata <= RST_BYTE;
            endcase
        end
    end

    assign baud_divisor = {div_hi_q, div_lo_q};
    assign line_format_control = lfc_q;
    assign int_enable_mask = ien_q;
    assign fifo_setup = fifo_q;
    assign modem_line_control = mlc_q;

    // ==========================================
    // Checks
    a_key_keeps_low: assert property (@(posedge clk) disable iff (!rstn)
        (wr && addr == OFS_LFC && wdata == ENH_KEY) |=> (lfc_q == {1'b1, $past(lfc_q[6:0])}))
        else $error("key write changed format bits");
    a_key_sets: assert property (@(posedge clk) disable iff (!rstn)
        (wr && addr == OFS_LFC) |=> (key_q == ($past(wdata) == ENH_KEY)))
        else $error("650 key tracking wrong");
    a_div_low: assert property (@(posedge clk) disable iff (!rstn)
        (wr && lfc_q[DLAB_BIT] && !key_q && addr == OFS_HOLD) |=> (baud_divisor[7:0] == $past(wdata)))
        else $error("divisor low not written");
    a_div_no_tx: assert property (@(posedge clk) disable iff (!rstn)
        (wr && lfc_q[DLAB_BIT] && addr == OFS_HOLD) |=> !tx_push)
        else $error("transmit pushed under divisor access");
    a_tx_push: assert property (@(posedge clk) disable iff (!rstn)
        (wr && !lfc_q[DLAB_BIT] && !key_q && addr == OFS_HOLD) |=> (tx_push && tx_data == $past(wdata)))
        else $error("transmit character lost");
    a_scr_store: assert property (@(posedge clk) disable iff (!rstn)
        (wr && !key_q && addr == OFS_SCR) |=> (scr_q == $past(wdata)))
        else $error("scratch not stored");
    a_bit9: assert property (@(posedge clk) disable iff (!rstn)
        nine_bit_mode |-> (tx_bit9 == scr_q[0]))
        else $error("ninth bit wrong");
    a_no950_key: assert property (@(posedge clk) disable iff (!rstn)
        key_q |-> (sel != SEL_950))
        else $error("950 set reached after key");
    a_950_map: assert property (@(posedge clk) disable iff (!rstn)
        (!key_q && !lfc_q[DLAB_BIT] && additional_setup_reg[SET950_BIT] && addr == OFS_IEN) |-> (sel == SEL_950))
        else $error("950 set not mapped");
    a_idx_read: assert property (@(posedge clk) disable iff (!rstn)
        (rd && !key_q && addr == OFS_IDXWIN && additional_setup_reg[IDXRD_BIT]) |=> (rdata == $past(idx_rdata)))
        else $error("indexed read wrong");
endmodule // uart_register_window_decode
`default_nettype wire

// ---- uart_far_side_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module uart_far_side_model #(
    parameter logic [7:0] EXT_VAL = 8'h5a
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Receive path and extended set
    input wire logic rx_pop,
    output logic [7:0] rx_data,
    output logic [7:0] ext_rdata
);
    // Next character is offered once the current one is popped
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rx_data <= 8'h61;
        else if (rx_pop) rx_data <= rx_data + 8'h01;
    end
    assign ext_rdata = EXT_VAL;
endmodule // uart_far_side_model
`default_nettype wire

// ---- uart_register_window_decode_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module uart_register_window_decode_tb_top;
    import uart_window_pkg::*;
    // ==========================================
    // Signals
    logic clk = 0, rstn = 0, cs = 0, wr_stb = 0, rd_stb = 0, nine_bit_mode = 0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, tx_data, rx_data, ext_rdata, lfc, ien, fifo, mlc, setup_reg;
    logic [7:0] int_source = 8'hc1, line_state = 8'h60, modem_line_state = 8'hb0;
    logic tx_push, tx_bit9, rx_pop, ext_wr, ext_rd;
    logic [15:0] baud_divisor;
    sel_t ext_set;
    int err_total = 0, num_checks = 0;
    always #2 clk = ~clk;
    uart_register_window_decode uart_register_window_decode_i (.clk(clk), .rstn(rstn), .addr(addr), .cs(cs),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .wdata(wdata), .rdata(rdata), .tx_push(tx_push), .tx_data(tx_data),
        .tx_bit9(tx_bit9), .rx_pop(rx_pop), .rx_data(rx_data), .nine_bit_mode(nine_bit_mode),
        .int_source(int_source), .line_state(line_state), .modem_line_state(modem_line_state),
        .ext_rdata(ext_rdata), .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_set(ext_set), .baud_divisor(baud_divisor),
        .line_format_control(lfc), .int_enable_mask(ien), .fifo_setup(fifo), .modem_line_control(mlc),
        .additional_setup_reg(setup_reg));
    uart_far_side_model #(.EXT_VAL(8'h5a)) uart_far_side_model_i (.clk(clk), .rstn(rstn), .rx_pop(rx_pop),
        .rx_data(rx_data), .ext_rdata(ext_rdata));
    // ==========================================
    // Tasks
    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        cs <= 1'b1;
        wr_stb <= 1'b1;
        @(posedge clk);
        cs <= 1'b0;
        wr_stb <= 1'b0;
        #1;
    endtask
    // Read one byte; when x is set the extended set must be the one answering
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic x = 1'b0, input sel_t s = SEL_650);
        @(posedge clk);
        addr <= a;
        cs <= 1'b1;
        rd_stb <= 1'b1;
        #1;
        if (x) chk({ext_rd, 3'h0, ext_set}, {1'b1, 3'h0, s});
        @(posedge clk);
        cs <= 1'b0;
        rd_stb <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
    // ==========================================
    // Tests
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd(OFS_LFC, RST_LFC);
        rd(OFS_SCR, RST_BYTE);
        $display("test reset done");
        wr(OFS_HOLD, 8'h3c);
        #1;
        chk({tx_push, tx_data}, {1'b1, 8'h3c});
        rd(OFS_HOLD, 8'h61);
        rd(OFS_HOLD, 8'h62);
        wr(OFS_IEN, 8'h0f);
        wr(OFS_FIFO, 8'h07);
        wr(OFS_MLC, 8'h13);
        chk({ien, fifo, mlc}, 24'h0f0713);
        rd(OFS_IEN, 8'h0f);
        rd(OFS_FIFO, 8'hc1);
        rd(OFS_LST, 8'h60);
        rd(OFS_MST, 8'hb0);
        $display("test base done");
        wr(OFS_LFC, 8'h83);
        wr(OFS_HOLD, 8'h12);
        #1;
        chk(tx_push, 1'b0);
        wr(OFS_IEN, 8'h34);
        chk(baud_divisor, 16'h3412);
        rd(OFS_HOLD, 8'h12);
        rd(OFS_IEN, 8'h34);
        wr(OFS_LFC, 8'h05);
        rd(OFS_IEN, 8'h0f);
        $display("test divisor done");
        wr(OFS_LFC, ENH_KEY);
        chk(lfc, 8'h85);
        rd(OFS_FIFO, 8'h5a, 1'b1, SEL_650);
        wr(OFS_LFC, 8'h05);
        rd(OFS_FIFO, 8'hc1);
        $display("test key done");
        wr(OFS_SCR, 8'ha5);
        rd(OFS_SCR, 8'ha5);
        nine_bit_mode <= 1'b1;
        #1;
        chk(tx_bit9, 1'b1);
        wr(OFS_SCR, 8'hfe);
        #1;
        chk(tx_bit9, 1'b0);
        $display("test scratch done");
        wr(OFS_SCR, IDX_SETUP);
        wr(OFS_IDXWIN, 8'h40);
        chk(setup_reg, 8'h40);
        rd(OFS_IDXWIN, 8'h40);
        wr(OFS_SCR, 8'h20);
        wr(OFS_IDXWIN, 8'h77);
        rd(OFS_IDXWIN, 8'h00);
        wr(OFS_SCR, IDX_SETUP);
        rd(OFS_IDXWIN, 8'h40);
        wr(OFS_IDXWIN, 8'h80);
        rd(OFS_MLC, 8'h5a, 1'b1, SEL_950);
        wr(OFS_HOLD, 8'h4d);
        chk({tx_push, tx_data}, {1'b1, 8'h4d});
        wr(OFS_LFC, ENH_KEY);
        rd(OFS_MLC, 8'h5a, 1'b1, SEL_650);
        $display("test indexed done");
        report_and_stop();
    end
endmodule // uart_register_window_decode_tb_top
`default_nettype wire
